/* File: rtl/mtlb_consts.svh */
// address decode, field positions and fixed codes of the memory-mapped tlb port
`ifndef MTLB_CONSTS_SVH
`define MTLB_CONSTS_SVH
`define MTLB_AREA_ADDR_ARRAY 8'hf2
`define MTLB_AREA_DATA_ARRAY 8'hf3
`define MTLB_AREA_HI 31
`define MTLB_AREA_LO 24
`define MTLB_INDEX_HI 16
`define MTLB_INDEX_LO 12
`define MTLB_WAY_HI 9
`define MTLB_WAY_LO 8
`define MTLB_ASSOC_BIT 7
`define MTLB_VPN_HI_HI 31
`define MTLB_VPN_HI_LO 17
`define MTLB_VPN_LO_HI 11
`define MTLB_VPN_LO_LO 10
`define MTLB_VALID_BIT 8
`define MTLB_TAG_HI 7
`define MTLB_TAG_LO 0
`define MTLB_PFN_HI 31
`define MTLB_PFN_LO 10
`define MTLB_RIGHTS_HI 6
`define MTLB_RIGHTS_LO 5
`define MTLB_SIZE_BIT 4
`define MTLB_CACHE_BIT 3
`define MTLB_DIRTY_BIT 2
`define MTLB_COMMON_BIT 1
`define MTLB_SIZE_LONGWORD 2'h2
`define MTLB_RESET_VALID 1'h0
`endif

/* File: rtl/mtlb_core_port.sv */
// core load/store end that issues tlb accesses over the link
`timescale 1ns/10ps
`include "mtlb_consts.svh"
module mtlb_core_port (
  // clock and reset
  input wire logic clk,
  input wire logic rst,
  // link to the tlb
  mtlb_if.core bus,
  // user command side
  input wire logic cmd_valid,
  input wire logic cmd_write,
  input wire logic [31:0] cmd_addr,
  input wire logic [31:0] cmd_wdata,
  input wire logic cmd_privileged,
  output logic cmd_ready,
  output logic resp_valid,
  output logic [31:0] resp_rdata
);
  import mtlb_pkg::*;

  // ==========================================================
  // state
  mtlb_port_state_t state, next_state;
  logic req, next_req;
  logic write, next_write;
  logic [31:0] addr, next_addr;
  logic [31:0] wdata, next_wdata;
  logic priv, next_priv;
  logic ready, next_ready;
  logic rvalid, next_rvalid;
  logic [31:0] rdata, next_rdata;

  always_comb begin
    next_state = state;
    next_req = 1'b0;
    next_write = write;
    next_addr = addr;
    next_wdata = wdata;
    next_priv = priv;
    next_ready = ready;
    next_rvalid = 1'b0;
    next_rdata = rdata;
    case (state)
      MTLB_IDLE: begin
        if (cmd_valid && ready) begin
          next_req = 1'b1;
          next_write = cmd_write;
          next_addr = cmd_addr;
          next_wdata = cmd_wdata;
          next_priv = cmd_privileged;
          next_ready = 1'b0;
          next_state = MTLB_WAIT;
        end
      end
      MTLB_WAIT: begin
        if (bus.ack) begin
          next_rvalid = 1'b1;
          next_rdata = bus.rdata;
          next_state = MTLB_DONE;
        end
      end
      MTLB_DONE: begin
        next_ready = 1'b1;
        next_state = MTLB_IDLE;
      end
      default: begin
        next_state = MTLB_IDLE;
        next_ready = 1'b1;
      end
    endcase
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      state <= MTLB_IDLE;
      req <= 1'b0;
      write <= 1'b0;
      addr <= 32'h0;
      wdata <= 32'h0;
      priv <= 1'b0;
      ready <= 1'b1;
      rvalid <= 1'b0;
      rdata <= 32'h0;
    end else begin
      state <= next_state;
      req <= next_req;
      write <= next_write;
      addr <= next_addr;
      wdata <= next_wdata;
      priv <= next_priv;
      ready <= next_ready;
      rvalid <= next_rvalid;
      rdata <= next_rdata;
    end
  end

  assign bus.req = req;
  assign bus.write = write;
  assign bus.addr = addr;
  assign bus.wdata = wdata;
  assign bus.size = `MTLB_SIZE_LONGWORD;
  assign bus.privileged = priv;
  assign cmd_ready = ready;
  assign resp_valid = rvalid;
  assign resp_rdata = rdata;
endmodule

/* File: rtl/mtlb_device.sv */
// four-way tlb with its address and data arrays reachable by longword loads and stores
`timescale 1ns/10ps
`include "mtlb_consts.svh"
module mtlb_device #(
  parameter int SETS = 32,
  parameter int WAYS = 4
) (
  // clock and reset
  input wire logic clk,
  input wire logic rst,
  // link to the core
  mtlb_if.device bus,
  // translation control and processor state
  input wire logic index_hash_enable,
  input wire logic single_space_mode,
  input wire logic privilege_level_bit,
  input wire logic [7:0] current_tag
);
  import mtlb_pkg::*;

  // ==========================================================
  // storage
  mtlb_addr_entry_t addr_ram [SETS][WAYS];
  mtlb_data_entry_t data_ram [SETS][WAYS];
  logic [WAYS-1:0] valid_ram [SETS];
  logic ack;
  logic [31:0] rdata;
  logic next_ack;
  logic [31:0] next_rdata;

  // ==========================================================
  // decode
  logic legal;
  logic in_addr_area;
  logic in_data_area;
  logic assoc;
  logic [4:0] index;
  logic [1:0] way_sel;
  logic [16:0] wr_vpn;
  logic [7:0] wr_tag;
  logic [WAYS-1:0] hit;

  assign legal = bus.req && bus.privileged && bus.size == `MTLB_SIZE_LONGWORD;
  assign in_addr_area = bus.addr[`MTLB_AREA_HI:`MTLB_AREA_LO] == `MTLB_AREA_ADDR_ARRAY;
  assign in_data_area = bus.addr[`MTLB_AREA_HI:`MTLB_AREA_LO] == `MTLB_AREA_DATA_ARRAY;
  assign assoc = bus.addr[`MTLB_ASSOC_BIT];
  // hashing spreads address spaces over the sets, same for both views
  assign index = bus.addr[`MTLB_INDEX_HI:`MTLB_INDEX_LO] ^ (index_hash_enable ? current_tag[4:0] : 5'h0);
  assign way_sel = bus.addr[`MTLB_WAY_HI:`MTLB_WAY_LO];
  assign wr_vpn = {bus.wdata[`MTLB_VPN_HI_HI:`MTLB_VPN_HI_LO], bus.wdata[`MTLB_VPN_LO_HI:`MTLB_VPN_LO_LO]};
  assign wr_tag = bus.wdata[`MTLB_TAG_HI:`MTLB_TAG_LO];

  // ==========================================================
  // associative compare, criteria of normal translation
  for (genvar w = 0; w < WAYS; w++) begin : g_cmp
    logic hi_eq;
    logic lo_eq;
    logic tag_eq;
    mtlb_addr_entry_t ae;
    mtlb_data_entry_t de;
    assign ae = addr_ram[index][w];
    assign de = data_ram[index][w];
    assign hi_eq = ae.virtual_page_number[16:2] == wr_vpn[16:2];
    // large pages do not look at the two low page bits
    assign lo_eq = de.page_size_bit || ae.virtual_page_number[1:0] == wr_vpn[1:0];
    assign tag_eq = de.common_mapping_bit || (single_space_mode && privilege_level_bit)
      || ae.address_space_tag == wr_tag;
    assign hit[w] = hi_eq && lo_eq && tag_eq;
  end

  // ==========================================================
  // lowest hitting way wins if software left duplicates
  logic [WAYS-1:0] hit_seen;
  logic [WAYS-1:0] first_hit;
  logic [1:0] hit_way;
  for (genvar w = 0; w < WAYS; w++) begin : g_pick
    if (w == 0) begin : g_low
      assign hit_seen[w] = hit[w];
      assign first_hit[w] = hit[w];
    end else begin : g_up
      assign hit_seen[w] = hit_seen[w-1] || hit[w];
      assign first_hit[w] = hit[w] && !hit_seen[w-1];
    end
  end

  always_comb begin
    hit_way = 2'h0;
    for (int w = 0; w < WAYS; w++) begin
      if (first_hit[w]) begin
        hit_way = w[1:0];
      end
    end
  end

  // ==========================================================
  // next values
  logic wr_addr_en;
  logic wr_data_en;
  logic [1:0] wr_way;
  logic wr_valid;
  mtlb_addr_entry_t rd_ae;
  mtlb_data_entry_t rd_de;
  logic rd_v;

  assign rd_ae = addr_ram[index][way_sel];
  assign rd_de = data_ram[index][way_sel];
  assign rd_v = valid_ram[index][way_sel];

  always_comb begin
    next_ack = bus.req;
    next_rdata = 32'h0;
    wr_addr_en = 1'b0;
    wr_data_en = 1'b0;
    wr_way = way_sel;
    wr_valid = bus.wdata[`MTLB_VALID_BIT];
    if (legal && in_addr_area) begin
      if (bus.write) begin
        if (assoc) begin
          wr_addr_en = |hit;
          wr_way = hit_way;
        end else begin
          wr_addr_en = 1'b1;
        end
      end else begin
        next_rdata[`MTLB_VPN_HI_HI:`MTLB_VPN_HI_LO] = rd_ae.virtual_page_number[16:2];
        next_rdata[`MTLB_VPN_LO_HI:`MTLB_VPN_LO_LO] = rd_ae.virtual_page_number[1:0];
        next_rdata[`MTLB_VALID_BIT] = rd_v;
        next_rdata[`MTLB_TAG_HI:`MTLB_TAG_LO] = rd_ae.address_space_tag;
      end
    end else if (legal && in_data_area) begin
      if (bus.write) begin
        wr_data_en = 1'b1;
      end else begin
        next_rdata[`MTLB_PFN_HI:`MTLB_PFN_LO] = rd_de.physical_frame_number;
        next_rdata[`MTLB_VALID_BIT] = rd_v;
        next_rdata[`MTLB_RIGHTS_HI:`MTLB_RIGHTS_LO] = rd_de.access_rights_key;
        next_rdata[`MTLB_SIZE_BIT] = rd_de.page_size_bit;
        next_rdata[`MTLB_CACHE_BIT] = rd_de.cacheable;
        next_rdata[`MTLB_DIRTY_BIT] = rd_de.dirty;
        next_rdata[`MTLB_COMMON_BIT] = rd_de.common_mapping_bit;
      end
    end
  end

  // ==========================================================
  // storage update, whole arrays so the registers only copy
  mtlb_addr_entry_t next_addr_ram [SETS][WAYS];
  mtlb_data_entry_t next_data_ram [SETS][WAYS];
  logic [WAYS-1:0] next_valid_ram [SETS];

  always_comb begin
    next_addr_ram = addr_ram;
    next_data_ram = data_ram;
    next_valid_ram = valid_ram;
    if (wr_addr_en) begin
      next_addr_ram[index][wr_way] = '{virtual_page_number: wr_vpn, address_space_tag: wr_tag};
    end
    if (wr_data_en) begin
      next_data_ram[index][wr_way] = '{
        physical_frame_number: bus.wdata[`MTLB_PFN_HI:`MTLB_PFN_LO],
        access_rights_key: bus.wdata[`MTLB_RIGHTS_HI:`MTLB_RIGHTS_LO],
        page_size_bit: bus.wdata[`MTLB_SIZE_BIT],
        cacheable: bus.wdata[`MTLB_CACHE_BIT],
        dirty: bus.wdata[`MTLB_DIRTY_BIT],
        common_mapping_bit: bus.wdata[`MTLB_COMMON_BIT]};
    end
    if (wr_addr_en || wr_data_en) begin
      next_valid_ram[index][wr_way] = wr_valid;
    end
  end

  // ==========================================================
  // registers
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      ack <= 1'b0;
      rdata <= 32'h0;
      for (int s = 0; s < SETS; s++) begin
        valid_ram[s] <= {WAYS{`MTLB_RESET_VALID}};
      end
    end else begin
      ack <= next_ack;
      rdata <= next_rdata;
      valid_ram <= next_valid_ram;
    end
  end

  // arrays other than valid get no reset, and the associative compare does not check valid, so invalid entries can still hit
  always_ff @(posedge clk) begin
    addr_ram <= next_addr_ram;
    data_ram <= next_data_ram;
  end

  assign bus.ack = ack;
  assign bus.rdata = rdata;
endmodule

/* File: rtl/mtlb_if.sv */
// load/store link between core and the memory-mapped tlb
`timescale 1ns/10ps
interface mtlb_if;
  logic req;
  logic write;
  logic [31:0] addr;
  logic [31:0] wdata;
  mtlb_pkg::mtlb_access_size_t size;
  logic privileged;
  logic ack;
  logic [31:0] rdata;
  modport device (input req, write, addr, wdata, size, privileged, output ack, rdata);
  modport core (output req, write, addr, wdata, size, privileged, input ack, rdata);
endinterface

/* File: rtl/mtlb_pkg.sv */
// types shared by both ends of the memory-mapped tlb port
package mtlb_pkg;
  typedef logic [1:0] mtlb_access_size_t;
  typedef struct packed {
    logic [16:0] virtual_page_number;
    logic [7:0] address_space_tag;
  } mtlb_addr_entry_t;
  typedef struct packed {
    logic [21:0] physical_frame_number;
    logic [1:0] access_rights_key;
    logic page_size_bit;
    logic cacheable;
    logic dirty;
    logic common_mapping_bit;
  } mtlb_data_entry_t;
  typedef enum logic [1:0] {MTLB_IDLE, MTLB_WAIT, MTLB_DONE} mtlb_port_state_t;
endpackage

/* File: test/memory_mapped_tlb_access_tb.sv */
// self-checking bench: core port and tlb joined over the link, against an array model
`timescale 1ns/10ps
module memory_mapped_tlb_access_tb;
  import mtlb_pkg::*;
  logic clk = 0;
  logic rst = 1;
  logic cv = 0, cw = 0, cp = 0, ihe = 0, ssm = 0, plb = 0;
  logic [31:0] ca = '0, cd = '0;
  logic [7:0] ctag = '0;
  logic cr, rv;
  logic [31:0] rr;
  int fails = 0, num_checks = 0, cyc = 0;
  logic [16:0] mv [128];
  logic [7:0] mt [128];
  logic mvld [128];
  logic [31:0] md [128];
  mtlb_if link ();
  mtlb_core_port i_mtlb_core_port (.clk(clk), .rst(rst), .bus(link), .cmd_valid(cv), .cmd_write(cw),
    .cmd_addr(ca), .cmd_wdata(cd), .cmd_privileged(cp), .cmd_ready(cr), .resp_valid(rv), .resp_rdata(rr));
  mtlb_device i_mtlb_device (.clk(clk), .rst(rst), .bus(link), .index_hash_enable(ihe),
    .single_space_mode(ssm), .privilege_level_bit(plb), .current_tag(ctag));
  mtlb_props i_mtlb_props (.clk(clk), .rst(rst), .req(link.req), .write(link.write), .addr(link.addr),
    .wdata(link.wdata), .size(link.size), .privileged(link.privileged), .ack(link.ack), .rdata(link.rdata));
  initial begin
    forever #2.5 clk = ~clk;
  end
  // ===========================
  // hang guard, well above the ~3.5k cycles of the run
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 40000) begin
      fails++;
      final_report();
    end
  end
  task automatic final_report();
    $display("checks %0d mismatches %0d", num_checks, fails);
    if (fails == 0 && num_checks > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp) begin
      fails++;
      $display("mismatch at %0t: got %h want %h", $time, got, exp);
    end
  endtask
  // ===========================
  // one command through the core port, held until taken
  task automatic acc(input logic w, input logic [31:0] a, input logic [31:0] d, input logic p);
    @(posedge clk);
    cv <= 1'b1;
    cw <= w;
    ca <= a;
    cd <= d;
    cp <= p;
    do @(negedge clk); while (cr !== 1'b1);
    @(posedge clk);
    cv <= 1'b0;
    do @(negedge clk); while (rv !== 1'b1);
  endtask
  function automatic logic match(int k, logic [31:0] d);
    return (d[31:17] == mv[k][16:2]) && (md[k][4] || d[11:10] == mv[k][1:0]) &&
      (md[k][1] || (ssm && plb) || d[7:0] == mt[k]);
  endfunction
  task automatic model(input logic w, input logic [31:0] a, input logic [31:0] d, input logic p,
    output logic [31:0] e);
    int s, k;
    e = '0;
    s = a[16:12] ^ (ihe ? ctag[4:0] : 5'h0);
    k = s * 4 + a[9:8];
    if (!p || !(a[31:24] inside {8'hf2, 8'hf3})) return;
    if (a[31:24] == 8'hf3) begin
      if (w) begin
        md[k] = d & 32'hfffffc7e;
        mvld[k] = d[8];
      end else e = md[k] | {23'h0, mvld[k], 8'h0};
      return;
    end
    if (!w) e = {mv[k][16:2], 5'h0, mv[k][1:0], 1'b0, mvld[k], mt[k]};
    else if (!a[7]) {mv[k], mt[k], mvld[k]} = {d[31:17], d[11:10], d[7:0], d[8]};
    else begin
      k = -1;
      for (int i = 3; i >= 0; i--) if (match(s * 4 + i, d)) k = s * 4 + i;
      if (k >= 0) {mv[k], mt[k], mvld[k]} = {d[31:17], d[11:10], d[7:0], d[8]};
    end
  endtask
  task automatic run(input logic w, input logic [31:0] a, input logic [31:0] d, input logic p);
    logic [31:0] e;
    acc(w, a, d, p);
    model(w, a, d, p, e);
    chk(rr, e);
  endtask
  // ===========================
  // reset valid check, fill both views, then random traffic
  initial begin
    int k, j;
    logic [31:0] r, a, d, t;
    void'($urandom(33));
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    for (int i = 0; i < 4; i++) begin
      acc(1'b0, 32'hf2000000 | (i << 12) | (i << 8), 32'h0, 1'b1);
      chk({31'h0, rr[8]}, 32'h0);
    end
    for (k = 0; k < 128; k++) begin
      run(1'b1, {8'hf2, 7'h0, k[6:2], 2'h0, k[1:0], 8'h0}, $urandom, 1'b1);
      run(1'b1, {8'hf3, 7'h0, k[6:2], 2'h0, k[1:0], 8'h0}, $urandom, 1'b1);
    end
    repeat (500) begin
      r = $urandom;
      t = $urandom;
      k = $urandom_range(127);
      @(posedge clk);
      ihe <= r[0];
      ssm <= r[1];
      plb <= r[2];
      ctag <= t[7:0];
      a = {r[5:4] == 2'h0 ? 8'hf1 : r[4] ? 8'hf3 : 8'hf2, 7'h0, k[6:2], 2'h0, k[1:0], r[6], 7'h0};
      j = {k[6:2] ^ (r[0] ? t[4:0] : 5'h0), k[1:0]};
      d = $urandom;
      // aim half the stores at a stored page so associative hits occur
      if (r[7]) d = {mv[j][16:2], 5'h0, mv[j][1:0], d[9:8], mt[j]};
      run(r[8] | r[6], a, d, r[11:9] != 3'h0);
    end
    final_report();
  end
endmodule

/* File: test/mtlb_props.sv */
// link assertions between the core port and the tlb
`timescale 1ns/10ps
module mtlb_props (
  // clock and reset
  input wire logic clk,
  input wire logic rst,
  // link
  input wire logic req,
  input wire logic write,
  input wire logic [31:0] addr,
  input wire logic [31:0] wdata,
  input wire mtlb_pkg::mtlb_access_size_t size,
  input wire logic privileged,
  input wire logic ack,
  input wire logic [31:0] rdata
);
  import mtlb_pkg::*;
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  wire logic rd = req && !write && privileged;
  // ===========================
  // answer timing and refusals
  a_ack_follows_req: assert property (req |=> ack) else $error("ack missing");
  a_ack_has_cause: assert property (ack |-> $past(req)) else $error("ack without request");
  a_unpriv_zero: assert property (req && !privileged |=> rdata == 32'h0) else $error("unprivileged data");
  a_foreign_zero: assert property (req && !(addr[31:24] inside {8'hf2, 8'hf3}) |=> rdata == 32'h0)
    else $error("foreign area data");
  a_store_zero: assert property (req && write |=> rdata == 32'h0) else $error("store returned data");
  a_rdata_idle: assert property (!req |=> rdata == 32'h0) else $error("rdata not cleared");
  // ===========================
  // read formats and requester conduct
  a_addr_form: assert property (rd && addr[31:24] == 8'hf2 |=> rdata[16:12] == 5'h0 && !rdata[9])
    else $error("address view spare bits");
  a_data_form: assert property (rd && addr[31:24] == 8'hf3 |=> !rdata[9] && !rdata[7] && !rdata[0])
    else $error("data view spare bits");
  a_size_long: assert property (req |-> size == 2'h2) else $error("not longword");
  a_req_spacing: assert property (req |=> !req [*2]) else $error("requests too close");
  cover property (rd && addr[31:24] == 8'hf2);
  cover property (req && write && addr[7] && addr[31:24] == 8'hf2 && wdata[8] == 1'b0);
  cover property (req && write && addr[31:24] == 8'hf3);
endmodule
